// [hdl/dp_lane_pkg.sv]
package dp_lane_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_EQ13  = 8'h10;
  localparam logic [7:0] OFS_EQ02  = 8'h11;
  localparam logic [7:0] OFS_SNOOP = 8'h12;
  localparam logic [7:0] OFS_CTRL  = 8'h13;

  // ----------------------------------------------------------------
  // field positions and masks
  // ----------------------------------------------------------------
  localparam int         EQ_HI_LSB     = 4;
  localparam int         PWR_LSB       = 5;
  localparam int         SNOOP_OFF_BIT = 7;
  localparam int         FORCE_LSB     = 4;
  localparam logic [7:0] CTRL_WR_MASK  = 8'hBF;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] READ_NONE     = 8'h00;

  // ----------------------------------------------------------------
  // snooped sink addresses and decoded values
  // ----------------------------------------------------------------
  localparam logic [19:0] DPCD_POWER  = 20'h00600;
  localparam logic [19:0] DPCD_LANES  = 20'h00101;
  localparam logic [1:0]  PWR_ON      = 2'h1;
  localparam logic [1:0]  PWR_CLEAR   = 2'h0;
  localparam logic [4:0]  CNT_CLEAR   = 5'h00;
  localparam logic [4:0]  CNT_ONE     = 5'h01;
  localparam logic [4:0]  CNT_TWO     = 5'h02;
  localparam logic [4:0]  CNT_FOUR    = 5'h04;
  localparam logic [3:0]  LANES_NONE  = 4'h0;
  localparam logic [3:0]  LANES_ONE   = 4'h1;
  localparam logic [3:0]  LANES_TWO   = 4'h3;
  localparam logic [3:0]  LANES_FOUR  = 4'hF;

  // ----------------------------------------------------------------
  // lane configuration and sideband force codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CFG_OFF      = 2'h0;
  localparam logic [1:0] CFG_USB      = 2'h1;
  localparam logic [1:0] CFG_DP4      = 2'h2;
  localparam logic [1:0] CFG_DP2_USB  = 2'h3;
  localparam logic [1:0] FORCE_FOLLOW = 2'h0;
  localparam logic [1:0] FORCE_N1_P2  = 2'h1;
  localparam logic [1:0] FORCE_N2_P1  = 2'h2;
  localparam logic [1:0] FORCE_OPEN   = 2'h3;

  // ----------------------------------------------------------------
  // serial target
  // ----------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR  = 7'h2A; // arbitrary value
  localparam logic [3:0] BITS_IN_BYTE = 4'h8;
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [3:0] CNT_STEP     = 4'h1;
  localparam logic [7:0] PTR_STEP     = 8'h01;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DEV  = 5'h02,
    ST_SUB  = 5'h04,
    ST_WR   = 5'h08,
    ST_RD   = 5'h10
  } serial_state_t;
endpackage : dp_lane_pkg

// [hdl/serial_target.sv]
`timescale 1ns/1ps
module serial_target
  import dp_lane_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // two-wire pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe,
  // register side
  output logic            wr_en,
  output logic [7:0]      reg_addr,
  output logic [7:0]      wr_data,
  input  wire logic [7:0] rd_data
);
  serial_state_t state_r;
  logic          scl_prev_r;
  logic          sda_prev_r;
  logic [3:0]    cnt_r;
  logic [7:0]    shift_r;
  logic [7:0]    tx_r;
  logic          ack_r;
  logic          nack_r;
  logic          rise;
  logic          fall;
  logic          start_c;
  logic          stop_c;
  logic          byte_done;
  logic          wr_step_r;

  // ----------------------------------------------------------------
  // bus event decode
  // ----------------------------------------------------------------
  assign rise      = scl_in & ~scl_prev_r;
  assign fall      = ~scl_in & scl_prev_r;
  assign start_c   = scl_in & scl_prev_r & sda_prev_r & ~sda_in;
  assign stop_c    = scl_in & scl_prev_r & ~sda_prev_r & sda_in;
  assign byte_done = fall & ~ack_r & (cnt_r == BITS_IN_BYTE);

  // pin history
  always_ff @(posedge clk) begin
    scl_prev_r <= reset ? 1'b1 : scl_in;
    sda_prev_r <= reset ? 1'b1 : sda_in;
  end

  // byte engine; sda only changes after scl falls, so data stays legal
  always_ff @(posedge clk) begin
    wr_en <= 1'b0;
    if (reset) begin
      state_r  <= ST_IDLE;
      cnt_r    <= CNT_ZERO;
      shift_r  <= REG_RESET;
      tx_r     <= REG_RESET;
      ack_r    <= 1'b0;
      nack_r   <= 1'b0;
      sda_oe   <= 1'b0;
      reg_addr <= REG_RESET;
      wr_data  <= REG_RESET;
    end else if (start_c) begin
      state_r <= ST_DEV;
      cnt_r   <= CNT_ZERO;
      ack_r   <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (stop_c) begin
      state_r <= ST_IDLE;
      sda_oe  <= 1'b0;
    end else if (rise && ack_r) begin
      nack_r <= sda_in;
    end else if (rise && state_r != ST_IDLE) begin
      shift_r <= {shift_r[6:0], sda_in};
      cnt_r   <= cnt_r + CNT_STEP;
    end else if (fall && ack_r) begin
      ack_r  <= 1'b0;
      cnt_r  <= CNT_ZERO;
      sda_oe <= 1'b0;
      if (state_r == ST_RD) begin
        if (nack_r) begin
          state_r <= ST_IDLE;
        end else begin
          tx_r     <= rd_data;
          sda_oe   <= ~rd_data[7];
          reg_addr <= reg_addr + PTR_STEP;
        end
      end
    end else if (byte_done) begin
      ack_r  <= 1'b1;
      sda_oe <= (state_r != ST_RD);
      case (state_r)
        ST_DEV: begin
          if (shift_r[7:1] != TARGET_ADDR) begin
            state_r <= ST_IDLE;
            ack_r   <= 1'b0;
            sda_oe  <= 1'b0;
          end else begin
            state_r <= shift_r[0] ? ST_RD : ST_SUB;
          end
        end
        ST_SUB: begin
          reg_addr <= shift_r;
          state_r  <= ST_WR;
        end
        ST_WR: begin
          wr_en   <= 1'b1;
          wr_data <= shift_r;
        end
        default: begin
        end
      endcase
    end else if (fall && state_r == ST_RD) begin
      tx_r   <= {tx_r[6:0], 1'b0};
      sda_oe <= ~tx_r[6];
    end
    // step last, after the strobe has used the old pointer
    if (wr_step_r && !reset) begin
      reg_addr <= reg_addr + PTR_STEP;
    end
  end

  // address pointer moves on after each written byte
  // (kept separate so a write lands before the pointer steps)
  always_ff @(posedge clk) begin
    wr_step_r <= reset ? 1'b0 : wr_en;
  end
endmodule : serial_target

// [hdl/dp_lane_eq_aux_snoop_regs.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - reg dp_lane1_lane3_eq holds lane1 eq high, lane3 low
// - reg dp_lane0_lane2_eq holds lane0 eq high, lane2 low
// - software select low: fields follow strap pins
// - software select high: eq follows written fields
// - snooped power-state write lands in bits 6:5
// - snoop on: power state gates lanes
// - snooped lane-count write lands in bits 4:0
// - snoop on: only counted lanes enabled
// - snoop off: lanes follow per-lane off bits
// - display enable falling clears power state
// - display enable falling clears lane count
// - control bit 7 high turns snooping off
// - force 01: auxn to sbu1, auxp to sbu2
// - force 10: auxn to sbu2, auxp to sbu1
// - force 11: both aux lines open
// - software select chooses strap or register eq
// - lane config decodes off, usb, dp4, dp2
module dp_lane_eq_aux_snoop_regs
  import dp_lane_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // two-wire register port
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // snooped aux writes
  input  wire logic        aux_wr_valid,
  input  wire logic [19:0] aux_wr_addr,
  input  wire logic [7:0]  aux_wr_data,
  // general configuration
  input  wire logic        eq_software_select,
  input  wire logic [1:0]  lane_config_select,
  input  wire logic        orientation_swap_select,
  input  wire logic [1:0]  display_eq_strap_pins,
  // lane equalization and enables
  output logic [3:0]       lane0_eq_level,
  output logic [3:0]       lane1_eq_level,
  output logic [3:0]       lane2_eq_level,
  output logic [3:0]       lane3_eq_level,
  output logic [3:0]       lane_on_r,
  // sideband switch
  output logic             auxn_sbu1_r,
  output logic             auxn_sbu2_r,
  output logic             auxp_sbu1_r,
  output logic             auxp_sbu2_r
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] count_mask(input logic [4:0] cnt);
    if (cnt == CNT_ONE) begin
      count_mask = LANES_ONE;
    end else if (cnt == CNT_TWO) begin
      count_mask = LANES_TWO;
    end else if (cnt == CNT_FOUR) begin
      count_mask = LANES_FOUR;
    end else begin
      count_mask = LANES_NONE;
    end
  endfunction : count_mask

  function automatic logic [3:0] config_mask(input logic [1:0] cfg);
    if (cfg == CFG_DP4) begin
      config_mask = LANES_FOUR;
    end else if (cfg == CFG_DP2_USB) begin
      config_mask = LANES_TWO;
    end else begin
      config_mask = LANES_NONE;
    end
  endfunction : config_mask

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic       wr_en;
  logic [7:0] reg_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  serial_target u_target (
    .clk      (clk),
    .reset    (reset),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_oe   (sda_oe),
    .wr_en    (wr_en),
    .reg_addr (reg_addr),
    .wr_data  (wr_data),
    .rd_data  (rd_data)
  );

  // open-drain pin only ever pulls low
  assign sda_out = 1'b0;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] eq13_r;
  logic [7:0] eq02_r;
  logic [1:0] pwr_r;
  logic [4:0] cnt_r;
  logic [7:0] ctrl_r;
  logic       dp_en_prev_r;

  // write strobes and snoop hits
  logic       wr_eq13;
  logic       wr_eq02;
  logic       wr_ctrl;
  logic       hit_pwr;
  logic       hit_cnt;
  logic       dp_en_fall;
  logic [3:0] strap_level;
  assign wr_eq13     = wr_en & (reg_addr == OFS_EQ13);
  assign wr_eq02     = wr_en & (reg_addr == OFS_EQ02);
  assign wr_ctrl     = wr_en & (reg_addr == OFS_CTRL);
  assign hit_pwr     = aux_wr_valid & (aux_wr_addr == DPCD_POWER);
  assign hit_cnt     = aux_wr_valid & (aux_wr_addr == DPCD_LANES);
  assign dp_en_fall  = dp_en_prev_r & ~lane_config_select[1];
  assign strap_level = {2'b00, display_eq_strap_pins};

  // equalization fields; strap tracking wins over software writes
  always_ff @(posedge clk) begin
    if (reset) begin
      eq13_r <= REG_RESET;
      eq02_r <= REG_RESET;
    end else if (!eq_software_select) begin
      eq13_r <= {strap_level, strap_level};
      eq02_r <= {strap_level, strap_level};
    end else begin
      if (wr_eq13) begin
        eq13_r <= wr_data;
      end
      if (wr_eq02) begin
        eq02_r <= wr_data;
      end
    end
  end

  // snoop capture; a capture in the clearing cycle is kept
  always_ff @(posedge clk) begin
    dp_en_prev_r <= reset ? 1'b0 : lane_config_select[1];
    if (reset) begin
      pwr_r <= PWR_CLEAR;
      cnt_r <= CNT_CLEAR;
    end else begin
      if (hit_pwr) begin
        pwr_r <= aux_wr_data[1:0];
      end else if (dp_en_fall) begin
        pwr_r <= PWR_CLEAR;
      end
      if (hit_cnt) begin
        cnt_r <= aux_wr_data[4:0];
      end else if (dp_en_fall) begin
        cnt_r <= CNT_CLEAR;
      end
    end
  end

  // control register; reserved bit 6 never stores
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= REG_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= wr_data & CTRL_WR_MASK;
    end
  end

  // read mux; unmapped offsets read zero
  assign rd_data =
    (reg_addr == OFS_EQ13)  ? eq13_r :
    (reg_addr == OFS_EQ02)  ? eq02_r :
    (reg_addr == OFS_SNOOP) ? {1'b0, pwr_r, cnt_r} :
    (reg_addr == OFS_CTRL)  ? ctrl_r : READ_NONE;

  assign lane1_eq_level = eq13_r[EQ_HI_LSB +: 4];
  assign lane3_eq_level = eq13_r[3:0];
  assign lane0_eq_level = eq02_r[EQ_HI_LSB +: 4];
  assign lane2_eq_level = eq02_r[3:0];

  // ----------------------------------------------------------------
  // lane enables
  // ----------------------------------------------------------------
  logic       snoop_on;
  logic [1:0] force_sel;
  logic [3:0] snoop_mask;
  logic [3:0] lane_nxt;
  assign snoop_on   = ~ctrl_r[SNOOP_OFF_BIT];
  assign force_sel  = ctrl_r[FORCE_LSB +: 2];
  assign snoop_mask = (pwr_r == PWR_ON) ? count_mask(cnt_r) : LANES_NONE;
  assign lane_nxt   = config_mask(lane_config_select) &
                      (snoop_on ? snoop_mask : ~ctrl_r[3:0]);

  // registered so the enables never glitch on a decode change
  always_ff @(posedge clk) begin
    lane_on_r <= reset ? LANES_NONE : lane_nxt;
  end

  // ----------------------------------------------------------------
  // sideband switch
  // ----------------------------------------------------------------
  logic follow_on;
  logic n1_nxt;
  logic n2_nxt;
  assign follow_on = lane_config_select[1];
  assign n1_nxt =
    (force_sel == FORCE_N1_P2) |
    ((force_sel == FORCE_FOLLOW) & follow_on & orientation_swap_select);
  assign n2_nxt =
    (force_sel == FORCE_N2_P1) |
    ((force_sel == FORCE_FOLLOW) & follow_on & ~orientation_swap_select);

  // p takes the sideband pin that n leaves, and is open whenever n is open
  always_ff @(posedge clk) begin
    auxn_sbu1_r <= reset ? 1'b0 : n1_nxt;
    auxp_sbu2_r <= reset ? 1'b0 : n1_nxt;
    auxn_sbu2_r <= reset ? 1'b0 : n2_nxt;
    auxp_sbu1_r <= reset ? 1'b0 : n2_nxt;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence force_held(logic [1:0] code);
    (force_sel == code) [*2];
  endsequence

  strap_track_a: assert property (!eq_software_select |=>
    eq13_r == {2{2'b00, $past(display_eq_strap_pins)}})
    else $error("eq field not tracking strap");
  sw_eq13_a: assert property (eq_software_select && wr_eq13 |=>
    lane1_eq_level == $past(wr_data[7:4]) &&
    lane3_eq_level == $past(wr_data[3:0]))
    else $error("lane1/lane3 eq write lost");
  sw_eq02_a: assert property (eq_software_select && wr_eq02 |=>
    lane0_eq_level == $past(wr_data[7:4]) &&
    lane2_eq_level == $past(wr_data[3:0]))
    else $error("lane0/lane2 eq write lost");
  pwr_snoop_a: assert property (hit_pwr |=>
    pwr_r == $past(aux_wr_data[1:0]))
    else $error("power state not captured");
  cnt_snoop_a: assert property (hit_cnt |=>
    cnt_r == $past(aux_wr_data[4:0]))
    else $error("lane count not captured");
  snoop_clear_a: assert property (dp_en_fall && !aux_wr_valid |=>
    pwr_r == PWR_CLEAR && cnt_r == CNT_CLEAR)
    else $error("snoop fields not cleared");
  pwr_gate_a: assert property ((snoop_on && pwr_r != PWR_ON) [*2] |->
    lane_on_r == LANES_NONE)
    else $error("lanes on while powered down");
  lane_count_a: assert property ((snoop_on && pwr_r == PWR_ON &&
    cnt_r == CNT_ONE && lane_config_select == CFG_DP4) [*2] |->
    lane_on_r == LANES_ONE)
    else $error("wrong lanes for count one");
  off_bits_a: assert property ((!snoop_on &&
    lane_config_select == CFG_DP4) [*2] |->
    lane_on_r == ~$past(ctrl_r[3:0]))
    else $error("lanes not following off bits");
  force_n1_a: assert property (force_held(FORCE_N1_P2) |->
    auxn_sbu1_r && auxp_sbu2_r && !auxn_sbu2_r && !auxp_sbu1_r)
    else $error("force 01 routing wrong");
  force_n2_a: assert property (force_held(FORCE_N2_P1) |->
    auxn_sbu2_r && auxp_sbu1_r && !auxn_sbu1_r && !auxp_sbu2_r)
    else $error("force 10 routing wrong");
  force_open_a: assert property (force_held(FORCE_OPEN) |->
    !auxn_sbu1_r && !auxn_sbu2_r && !auxp_sbu1_r && !auxp_sbu2_r)
    else $error("force 11 not open");
  reserved_zero_a: assert property (!ctrl_r[6] &&
    (reg_addr != OFS_SNOOP || !rd_data[7]))
    else $error("reserved bit reads one");
endmodule : dp_lane_eq_aux_snoop_regs

// [testbench/dp_host_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// two-wire host and aux source, driven on rising edges
// ------------------------------------------------------------
module dp_host_model
  import dp_lane_pkg::*;
(
  // clock and resolved data wire
  input  wire logic  clk,
  input  wire logic  sda,
  // two-wire drive, sda_low pulls the wire down
  output logic        scl,
  output logic        sda_low,
  // snooped aux writes
  output logic        aux_wr_valid,
  output logic [19:0] aux_wr_addr,
  output logic [7:0]  aux_wr_data
);
  // idle bus: both lines released, aux quiet
  initial begin
    scl          = 1'b1;
    sda_low      = 1'b0;
    aux_wr_valid = 1'b0;
    aux_wr_addr  = 20'h00000;
    aux_wr_data  = 8'h00;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // data moves one clock after scl falls, never with the edge
  task automatic bit_io(input logic b, output logic r);
    wait_clk(1);
    sda_low <= !b;
    wait_clk(3);
    scl <= 1'b1;
    wait_clk(2);
    r = sda;
    wait_clk(2);
    scl <= 1'b0;
  endtask : bit_io

  task automatic start_cond;
    sda_low <= 1'b0;
    scl     <= 1'b1;
    wait_clk(4);
    sda_low <= 1'b1;
    wait_clk(4);
    scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond;
    wait_clk(1);
    sda_low <= 1'b1;
    wait_clk(3);
    scl <= 1'b1;
    wait_clk(4);
    sda_low <= 1'b0;
    wait_clk(4);
  endtask : stop_cond

  // ack slot always released: target acks writes, host nacks reads
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
                         output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, a);
    ack = !a;
  endtask : byte_io

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
    logic [7:0] rx;
    logic       a1, a2, a3;
    start_cond();
    byte_io({TARGET_ADDR, 1'b0}, rx, a1);
    byte_io(a, rx, a2);
    byte_io(d, rx, a3);
    stop_cond();
    ok = a1 & a2 & a3;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
    logic [7:0] rx;
    logic       a1, a2, a3, a4;
    start_cond();
    byte_io({TARGET_ADDR, 1'b0}, rx, a1);
    byte_io(a, rx, a2);
    stop_cond();
    start_cond();
    byte_io({TARGET_ADDR, 1'b1}, rx, a3);
    byte_io(8'hFF, d, a4);
    stop_cond();
    ok = a1 & a2 & a3;
  endtask : read_reg

  // one-cycle pulse, then the bus shows garbage, not the old value
  task automatic aux_send(input logic [19:0] a, input logic [7:0] d);
    aux_wr_valid <= 1'b1;
    aux_wr_addr  <= a;
    aux_wr_data  <= d;
    wait_clk(1);
    aux_wr_valid <= 1'b0;
    aux_wr_addr  <= ~a;
    aux_wr_data  <= ~d;
    wait_clk(4);
  endtask : aux_send
endmodule : dp_host_model

// [testbench/test_dp_lane_eq_aux_snoop_regs.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD t=%0t got %0h exp %0h", $time, g, e); \
  end end
module test_dp_lane_eq_aux_snoop_regs;
  import dp_lane_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        clk, reset, scl, sda_low, sda, sda_oe, aux_v, sw, flip;
  logic        n1, n2, p1, p2, ok;
  logic [19:0] aux_a;
  logic [7:0]  aux_d, rd;
  logic [1:0]  cfg, strap;
  logic [3:0]  eq0, eq1, eq2, eq3, lanes;
  int          miscompares, tests_run;

  // open-drain wire with pull-up
  assign sda = !(sda_low || sda_oe);
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  dp_lane_eq_aux_snoop_regs dut_u (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .aux_wr_valid(aux_v), .aux_wr_addr(aux_a),
    .aux_wr_data(aux_d), .eq_software_select(sw),
    .lane_config_select(cfg), .orientation_swap_select(flip),
    .display_eq_strap_pins(strap), .lane0_eq_level(eq0),
    .lane1_eq_level(eq1), .lane2_eq_level(eq2), .lane3_eq_level(eq3),
    .lane_on_r(lanes), .auxn_sbu1_r(n1), .auxn_sbu2_r(n2),
    .auxp_sbu1_r(p1), .auxp_sbu2_r(p2));

  dp_host_model host_u (
    .clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low),
    .aux_wr_valid(aux_v), .aux_wr_addr(aux_a), .aux_wr_data(aux_d));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.write_reg(a, d, ok);
    `CHK(ok, 1'b1)
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host_u.read_reg(a, rd, ok);
    `CHK(ok, 1'b1)
    `CHK(rd, e)
  endtask : rd_chk

  task automatic drive(input logic [1:0] c, input logic f, input logic s);
    @(posedge clk);
    cfg  <= c;
    flip <= f;
    sw   <= s;
    host_u.wait_clk(4);
  endtask : drive

  // expected {auxn_sbu1, auxn_sbu2, auxp_sbu1, auxp_sbu2}
  function automatic logic [3:0] sbu_exp(input logic [1:0] f,
                                         input logic en, input logic fl);
    case (f)
      FORCE_N1_P2: return 4'h9;
      FORCE_N2_P1: return 4'h6;
      FORCE_OPEN:  return 4'h0;
      default:     return !en ? 4'h0 : (fl ? 4'h9 : 4'h6);
    endcase
  endfunction : sbu_exp

  function automatic logic [3:0] cnt_lanes(input logic [4:0] n);
    case (n)
      CNT_ONE:  return LANES_ONE;
      CNT_TWO:  return LANES_TWO;
      CNT_FOUR: return LANES_FOUR;
      default:  return LANES_NONE;
    endcase
  endfunction : cnt_lanes

  task automatic complete_run;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    sw = 1'b0;
    cfg = CFG_USB;
    flip = 1'b0;
    strap = 2'b00;
    miscompares = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    host_u.wait_clk(4);
    `CHK(lanes, LANES_NONE)
    `CHK({n1, n2, p1, p2}, 4'h0)
    rd_chk(OFS_SNOOP, REG_RESET);
    rd_chk(OFS_CTRL, REG_RESET);
    rd_chk(8'h20, READ_NONE);
    $display("test reset done");
    @(posedge clk) strap <= 2'b10;
    host_u.wait_clk(3);
    `CHK({eq0, eq1, eq2, eq3}, 16'h2222)
    wr(OFS_EQ13, 8'hA5);
    rd_chk(OFS_EQ13, 8'h22);
    drive(CFG_USB, 1'b0, 1'b1);
    wr(OFS_EQ13, 8'hA5);
    wr(OFS_EQ02, 8'h3C);
    `CHK({eq0, eq1, eq2, eq3}, 16'h3AC5)
    rd_chk(OFS_EQ02, 8'h3C);
    drive(CFG_USB, 1'b0, 1'b0);
    `CHK({eq0, eq1, eq2, eq3}, 16'h2222)
    $display("test equalization done");
    wr(OFS_CTRL, 8'hFF);
    rd_chk(OFS_CTRL, 8'hBF);
    wr(OFS_CTRL, 8'h80);
    for (int c = 0; c < 4; c++) begin
      drive(c[1:0], 1'b0, 1'b0);
      `CHK(lanes, c == 2 ? LANES_FOUR : c == 3 ? LANES_TWO : 4'h0)
    end
    wr(OFS_CTRL, 8'h85);
    drive(CFG_DP4, 1'b0, 1'b0);
    host_u.aux_send(DPCD_LANES, 8'h01);
    `CHK(lanes, 4'hA)
    $display("test lane off done");
    wr(OFS_CTRL, 8'h00);
    host_u.aux_send(DPCD_POWER, 8'h01);
    for (int k = 0; k < 4; k++) begin
      host_u.aux_send(DPCD_LANES, 8'(k == 3 ? 3 : 1 << k));
      `CHK(lanes, cnt_lanes(5'(k == 3 ? 3 : 1 << k)))
    end
    host_u.aux_send(DPCD_LANES, 8'h04);
    host_u.aux_send(20'h00602, 8'h00);
    `CHK(lanes, LANES_FOUR)
    rd_chk(OFS_SNOOP, 8'h24);
    wr(OFS_SNOOP, 8'hFF);
    rd_chk(OFS_SNOOP, 8'h24);
    host_u.aux_send(DPCD_POWER, 8'h02);
    `CHK(lanes, LANES_NONE)
    host_u.aux_send(DPCD_POWER, 8'h01);
    drive(CFG_DP2_USB, 1'b0, 1'b0);
    wr(OFS_CTRL, 8'h0F);
    `CHK(lanes, LANES_TWO)
    drive(CFG_USB, 1'b0, 1'b0);
    rd_chk(OFS_SNOOP, 8'h00);
    drive(CFG_DP4, 1'b0, 1'b0);
    `CHK(lanes, LANES_NONE)
    $display("test snoop done");
    for (int f = 0; f < 4; f++) begin
      wr(OFS_CTRL, {2'b10, f[1:0], 4'h0});
      for (int j = 0; j < 4; j++) begin
        drive(j[1] ? CFG_DP4 : CFG_USB, j[0], 1'b0);
        `CHK({n1, n2, p1, p2}, sbu_exp(f[1:0], j[1], j[0]))
      end
    end
    $display("test sideband done");
    complete_run();
  end

  // watchdog, well beyond the expected run of some 6200 cycles
  initial begin
    #(25 * 80000);
    miscompares++;
    $display("BAD t=%0t watchdog expired", $time);
    complete_run();
  end
endmodule : test_dp_lane_eq_aux_snoop_regs
